// *** hdl/apm_pkg.sv ***
// shared constants, state codes and carrier structs for the power manager
package apm_pkg;

   // floppy register offsets from the controller base
   localparam logic [2:0] OFS_STATUS_A = 3'h0;
   localparam logic [2:0] OFS_STATUS_B = 3'h1;
   localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;
   localparam logic [2:0] OFS_RATE_MAIN = 3'h4;
   localparam logic [2:0] OFS_DATA = 3'h5;
   localparam logic [2:0] OFS_INPUT_RATE = 3'h7;

   // drive_output_control fields
   localparam int DOR_MOTOR_LSB = 4;
   localparam int DOR_RESET_BIT = 2;
   localparam int DOR_SEL_LSB = 0;
   localparam logic [7:0] DOR_RESET_VAL = 8'h04;

   // rate_select and transfer_rate_control fields
   localparam int DSR_RESET_BIT = 7;
   localparam int DSR_PD_BIT = 6;
   localparam int RATE_LSB = 0;
   localparam logic [1:0] RATE_RESET_VAL = 2'h0;

   // controller_main_status value of an idle controller
   localparam logic [7:0] MSR_IDLE = 8'h80;

   // configuration bits
   localparam int CR1_PP_PD_BIT = 2;
   localparam int CR2_UART1_PD_BIT = 3;
   localparam int CR2_UART2_PD_BIT = 7;
   localparam int CR7_PP_AUTO_BIT = 4;
   localparam int CR7_UART1_AUTO_BIT = 5;
   localparam int CR7_UART2_AUTO_BIT = 6;
   localparam int CR7_FDC_AUTO_BIT = 7;

   // extended control register mode field codes
   localparam logic [2:0] ECR_STD = 3'h0;
   localparam logic [2:0] ECR_BIDIR = 3'h1;
   localparam logic [2:0] ECR_EPP = 3'h4;

   // floppy idle timer
   localparam int unsigned PD_IDLE_TIME_US = 10000;
   localparam int unsigned CLK_FREQ_MHZ = 100;
   localparam int unsigned PD_IDLE_CYCLES = PD_IDLE_TIME_US * CLK_FREQ_MHZ;

   typedef enum logic [1:0] {
      APM_FDC_AWAKE = 2'b00,
      APM_FDC_COUNT = 2'b01,
      APM_FDC_DOWN = 2'b11
   } apm_fdc_state_t;

   typedef struct packed {
      logic [7:0] cr1;
      logic [7:0] cr2;
      logic [7:0] cr7;
      logic epp_en;
      logic ecp_en;
      logic [2:0] ecr_mode;
   } apm_cfg_t;

   typedef struct packed {
      logic [7:0] status_a;
      logic [7:0] status_b;
      logic [7:0] main_status;
      logic [7:0] input_status;
      logic [7:0] data_rd;
      logic irq;
      logic head_unloaded;
      logic step;
      logic step_dir;
      logic head_side;
      logic density;
      logic write_stream;
      logic write_gate;
   } apm_fdc_core_t;

   typedef struct packed {
      logic read_data;
      logic write_protect;
      logic track_zero_in;
      logic index_pulse_in;
      logic second_drive_present;
      logic media_changed_in;
   } apm_drive_in_t;

   typedef struct packed {
      logic thr_empty;
      logic tsr_empty;
      logic rxf_empty;
      logic rx_idle;
      logic serial_receive_input;
      logic thr_write;
      logic ring_indicator;
   } apm_uart_in_t;

endpackage

// *** hdl/apm_idle_timer.sv ***
// floppy idle countdown timer with restart
`timescale 1ns/10ps
module apm_idle_timer #(
   parameter int unsigned CYCLES = apm_pkg::PD_IDLE_CYCLES
) (
   input wire logic clk_i,     // device clock
   input wire logic nrst_i,    // async reset, active low
   input wire logic run_i,     // count while high, clear while low
   input wire logic restart_i, // reload from zero
   output logic done_o         // countdown elapsed, level
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg <= '0;
         done_o <= 1'b0;
      end else if (!run_i || restart_i) begin
         cnt_reg <= '0;
         done_o <= 1'b0;
      end else if (!done_o) begin
         if (cnt_reg == LAST) begin
            done_o <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + W'(1);
         end
      end
   end
endmodule

// *** hdl/apm_uart_pd.sv ***
// serial port transmitter and receiver powerdown tracking
`timescale 1ns/10ps
module apm_uart_pd (
   input wire logic clk_i,               // device clock
   input wire logic nrst_i,              // async reset, active low
   input wire logic auto_en_i,           // auto powerdown enabled
   input wire logic direct_pd_i,         // direct powerdown bit
   input wire apm_pkg::apm_uart_in_t u_i, // serial port status
   output logic tx_pd_o,                 // transmitter powered down
   output logic rx_pd_o,                 // receiver powered down
   output logic ri_change_o              // ring input changed, pulse
);
   logic tx_auto_reg;
   logic rx_auto_reg;
   logic rxd_reg;
   logic ri_reg;
   logic rxd_edge;

   assign rxd_edge = u_i.serial_receive_input != rxd_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rxd_reg <= 1'b1;
         ri_reg <= 1'b0;
         ri_change_o <= 1'b0;
      end else begin
         rxd_reg <= u_i.serial_receive_input;
         ri_reg <= u_i.ring_indicator;
         // ring detection is never gated by powerdown
         ri_change_o <= u_i.ring_indicator != ri_reg;
      end
   end

   // wake beats entry in the same cycle so a host write is never lost
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_auto_reg <= 1'b0;
      end else if (!auto_en_i || u_i.thr_write) begin
         tx_auto_reg <= 1'b0;
      end else if (u_i.thr_empty && u_i.tsr_empty) begin
         tx_auto_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_auto_reg <= 1'b0;
      end else if (!auto_en_i || rxd_edge) begin
         rx_auto_reg <= 1'b0;
      end else if (u_i.rxf_empty && u_i.rx_idle) begin
         rx_auto_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_pd_o <= 1'b0;
         rx_pd_o <= 1'b0;
      end else begin
         tx_pd_o <= direct_pd_i || (tx_auto_reg && !u_i.thr_write);
         rx_pd_o <= direct_pd_i || (rx_auto_reg && !rxd_edge);
      end
   end
endmodule

// *** hdl/apm_power_mgr.sv ***
// auto power management for the floppy, serial and parallel functions
// What this block does
// - status, input and rate-control access stays asleep
// - main status read or data access wakes floppy
// - drive/rate writes wake only on motor/reset
// - host-side pins keep working in powerdown
// - drive-cable pins disabled, local pins untouched
// - motor, select, write data/gate tristated
// - step, head, density, rate stay driven
// - serial direct powerdown from config two bits
// - serial auto powerdown enabled from config seven
// - transmitter sleeps when buffer and shifter empty
// - receiver sleeps when FIFO empty and idle
// - ring change still reported while asleep
// - transmit buffer write wakes the transmitter
// - receive input change wakes the receiver
// - parallel direct powerdown from config one
// - parallel auto powerdown enabled by config seven
// - EPP sleeps when disabled or unselected
// - ECP sleeps when disabled or in standard, bidirectional or EPP mode
// - parallel state follows mode changes on the next clock
// - floppy enters after idle conditions and 10 ms
// - main status or data access restarts timer
// - register wake resumes without reset sequence
// - non-waking writes kept, shown after wake
`timescale 1ns/10ps
module apm_power_mgr #(
   parameter int unsigned IDLE_CYCLES = apm_pkg::PD_IDLE_CYCLES
) (
   input wire logic clk_i,                         // device clock, 100 MHz
   input wire logic nrst_i,                        // hardware reset, active low
   // host register port
   input wire logic [2:0] host_addr_i,             // floppy register offset
   input wire logic host_rd_i,                     // read strobe, one cycle
   input wire logic host_wr_i,                     // write strobe, one cycle
   input wire logic [7:0] host_wdata_i,            // write data
   output logic [7:0] host_rdata_o,                // read data, next cycle
   // configuration
   input wire apm_pkg::apm_cfg_t cfg_i,            // configuration registers
   // floppy core side
   input wire apm_pkg::apm_fdc_core_t fdc_i,       // floppy core status and drive
   output logic fdc_data_rd_o,                     // data port read, pulse
   output logic fdc_data_wr_o,                     // data port write, pulse
   output logic [7:0] fdc_data_o,                  // data port write value
   output logic fdc_sw_reset_o,                    // software reset request, pulse
   output logic fdc_pd_o,                          // floppy powered down
   // drive cable
   input wire apm_pkg::apm_drive_in_t drive_in_i,  // drive status pins
   output apm_pkg::apm_drive_in_t drive_in_o,      // drive status to core
   output logic [3:0] motor_on_outputs_o,          // motor enables
   output logic motor_on_oe_n_o,                   // motor enable drive, low drives
   output logic [3:0] drive_select_outputs_o,      // drive selects
   output logic drive_select_oe_n_o,               // select drive, low drives
   output logic write_stream_out_o,                // write data
   output logic write_stream_oe_n_o,               // write data drive, low drives
   output logic write_gate_o,                      // write gate
   output logic write_gate_oe_n_o,                 // write gate drive, low drives
   output logic step_pulse_o,                      // step pulse
   output logic step_dir_o,                        // step direction
   output logic head_side_select_o,                // head select
   output logic density_select_o,                  // density select
   output logic [1:0] rate_outputs_o,              // data rate pins
   // serial ports
   input wire apm_pkg::apm_uart_in_t [1:0] uart_i, // serial port status
   output logic [1:0] uart_tx_pd_o,                // transmitter powered down
   output logic [1:0] uart_rx_pd_o,                // receiver powered down
   output logic [1:0] uart_ri_change_o,            // ring change, pulse
   // parallel port
   output logic pp_pd_o,                           // whole parallel port down
   output logic epp_pd_o,                          // EPP sub-block down
   output logic ecp_pd_o                           // ECP sub-block down
);

   apm_pkg::apm_fdc_state_t fdc_state_reg;
   apm_pkg::apm_fdc_state_t fdc_state_next;

   logic [7:0] dor_reg;
   logic [1:0] rate_reg;
   logic dsr_pd_reg;
   logic fdc_auto_en;
   logic timer_done;
   logic timer_restart;
   logic idle_ok;
   logic acc_main_rd;
   logic acc_data;
   logic wr_dor;
   logic wr_dsr;
   logic wr_ccr;
   logic dor_wake;
   logic dsr_wake;
   logic wake;
   logic fdc_down;

   // ------------------------------------------------------------------
   // host access decode
   // ------------------------------------------------------------------
   assign acc_main_rd = host_rd_i && host_addr_i == apm_pkg::OFS_RATE_MAIN;
   assign acc_data = (host_rd_i || host_wr_i) && host_addr_i == apm_pkg::OFS_DATA;
   assign wr_dor = host_wr_i && host_addr_i == apm_pkg::OFS_DRIVE_OUT;
   assign wr_dsr = host_wr_i && host_addr_i == apm_pkg::OFS_RATE_MAIN;
   assign wr_ccr = host_wr_i && host_addr_i == apm_pkg::OFS_INPUT_RATE;

   // plain drive/rate writes stay asleep; motor bits or reset bits wake
   assign dor_wake = wr_dor &&
      (host_wdata_i[apm_pkg::DOR_MOTOR_LSB +: 4] != 4'h0 ||
       !host_wdata_i[apm_pkg::DOR_RESET_BIT]);
   assign dsr_wake = wr_dsr && host_wdata_i[apm_pkg::DSR_RESET_BIT];

   assign wake = acc_main_rd || acc_data || dor_wake || dsr_wake;

   // status reads, input reads and rate-control writes are not in wake
   assign timer_restart = acc_main_rd || acc_data;

   // ------------------------------------------------------------------
   // host-visible registers; they keep working in powerdown
   // ------------------------------------------------------------------
   // drive_output_control holds its value through powerdown
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dor_reg <= apm_pkg::DOR_RESET_VAL;
      end else if (wr_dor) begin
         dor_reg <= host_wdata_i;
      end
   end

   // both rate registers steer the same rate; the later write wins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rate_reg <= apm_pkg::RATE_RESET_VAL;
      end else if (wr_dsr || wr_ccr) begin
         rate_reg <= host_wdata_i[apm_pkg::RATE_LSB +: 2];
      end
   end

   // direct powerdown via rate_select overrides auto powerdown
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dsr_pd_reg <= 1'b0;
      end else if (wr_dsr) begin
         dsr_pd_reg <= host_wdata_i[apm_pkg::DSR_PD_BIT];
      end else if (wake) begin
         dsr_pd_reg <= 1'b0;
      end
   end

   // reads answer from live status even while asleep
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         host_rdata_o <= 8'h00;
      end else if (host_rd_i) begin
         unique case (host_addr_i)
            apm_pkg::OFS_STATUS_A: host_rdata_o <= fdc_i.status_a;
            apm_pkg::OFS_STATUS_B: host_rdata_o <= fdc_i.status_b;
            apm_pkg::OFS_DRIVE_OUT: host_rdata_o <= dor_reg;
            apm_pkg::OFS_RATE_MAIN: host_rdata_o <= fdc_i.main_status;
            apm_pkg::OFS_DATA: host_rdata_o <= fdc_i.data_rd;
            apm_pkg::OFS_INPUT_RATE: host_rdata_o <= fdc_i.input_status;
            default: host_rdata_o <= 8'h00;
         endcase
      end
   end

   // data port strobes pass to the core in every state
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fdc_data_rd_o <= 1'b0;
         fdc_data_wr_o <= 1'b0;
         fdc_data_o <= 8'h00;
      end else begin
         fdc_data_rd_o <= host_rd_i && host_addr_i == apm_pkg::OFS_DATA;
         fdc_data_wr_o <= host_wr_i && host_addr_i == apm_pkg::OFS_DATA;
         if (host_wr_i && host_addr_i == apm_pkg::OFS_DATA) begin
            fdc_data_o <= host_wdata_i;
         end
      end
   end

   // only an explicit reset bit resets the core; access wake does not
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fdc_sw_reset_o <= 1'b0;
      end else begin
         fdc_sw_reset_o <= (wr_dor && !host_wdata_i[apm_pkg::DOR_RESET_BIT]) ||
                           dsr_wake;
      end
   end

   // ------------------------------------------------------------------
   // floppy auto powerdown
   // ------------------------------------------------------------------
   assign fdc_auto_en = cfg_i.cr7[apm_pkg::CR7_FDC_AUTO_BIT];

   assign idle_ok = dor_reg[apm_pkg::DOR_MOTOR_LSB +: 4] == 4'h0 &&
                    fdc_i.main_status == apm_pkg::MSR_IDLE &&
                    !fdc_i.irq && fdc_i.head_unloaded;

   apm_idle_timer #(
      .CYCLES(IDLE_CYCLES)
   ) u_idle_timer (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .run_i(fdc_state_reg == apm_pkg::APM_FDC_COUNT),
      .restart_i(timer_restart),
      .done_o(timer_done)
   );

   always_comb begin
      fdc_state_next = fdc_state_reg;
      unique case (fdc_state_reg)
         apm_pkg::APM_FDC_AWAKE: begin
            if (fdc_auto_en) begin
               fdc_state_next = apm_pkg::APM_FDC_COUNT;
            end
         end
         apm_pkg::APM_FDC_COUNT: begin
            if (!fdc_auto_en) begin
               fdc_state_next = apm_pkg::APM_FDC_AWAKE;
            end else if (timer_done && idle_ok && !wake) begin
               fdc_state_next = apm_pkg::APM_FDC_DOWN;
            end
         end
         apm_pkg::APM_FDC_DOWN: begin
            if (!fdc_auto_en) begin
               fdc_state_next = apm_pkg::APM_FDC_AWAKE;
            end else if (wake) begin
               // back to countdown: the timer reloads for another full period
               fdc_state_next = apm_pkg::APM_FDC_COUNT;
            end
         end
         default: fdc_state_next = apm_pkg::APM_FDC_AWAKE;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fdc_state_reg <= apm_pkg::APM_FDC_AWAKE;
      end else begin
         fdc_state_reg <= fdc_state_next;
      end
   end

   assign fdc_down = fdc_state_next == apm_pkg::APM_FDC_DOWN ||
                     (dsr_pd_reg && !wake);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fdc_pd_o <= 1'b0;
      end else begin
         fdc_pd_o <= fdc_down;
      end
   end

   // ------------------------------------------------------------------
   // drive cable pins
   // ------------------------------------------------------------------
   // cable-facing outputs float while down so no current flows into the drive
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         motor_on_outputs_o <= 4'h0;
         motor_on_oe_n_o <= 1'b0;
         drive_select_outputs_o <= 4'h0;
         drive_select_oe_n_o <= 1'b0;
         write_stream_out_o <= 1'b0;
         write_stream_oe_n_o <= 1'b0;
         write_gate_o <= 1'b0;
         write_gate_oe_n_o <= 1'b0;
      end else begin
         motor_on_outputs_o <= dor_reg[apm_pkg::DOR_MOTOR_LSB +: 4];
         motor_on_oe_n_o <= fdc_down;
         drive_select_outputs_o <= 4'h1 << dor_reg[apm_pkg::DOR_SEL_LSB +: 2];
         drive_select_oe_n_o <= fdc_down;
         write_stream_out_o <= fdc_i.write_stream;
         write_stream_oe_n_o <= fdc_down;
         write_gate_o <= fdc_i.write_gate;
         write_gate_oe_n_o <= fdc_down;
      end
   end

   // these pins keep driving in powerdown
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         step_pulse_o <= 1'b0;
         step_dir_o <= 1'b0;
         head_side_select_o <= 1'b0;
         density_select_o <= 1'b0;
         rate_outputs_o <= apm_pkg::RATE_RESET_VAL;
      end else begin
         step_pulse_o <= fdc_i.step;
         step_dir_o <= fdc_i.step_dir;
         head_side_select_o <= fdc_i.head_side;
         density_select_o <= fdc_i.density;
         rate_outputs_o <= rate_reg;
      end
   end

   // drive inputs stay inputs and are never masked
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         drive_in_o <= '0;
      end else begin
         drive_in_o <= drive_in_i;
      end
   end

   // ------------------------------------------------------------------
   // serial ports
   // ------------------------------------------------------------------
   localparam int UART_PD_BIT [2] = '{apm_pkg::CR2_UART1_PD_BIT, apm_pkg::CR2_UART2_PD_BIT};
   localparam int UART_AUTO_BIT [2] = '{apm_pkg::CR7_UART1_AUTO_BIT,
                                        apm_pkg::CR7_UART2_AUTO_BIT};

   for (genvar i = 0; i < 2; i++) begin : g_uart
      apm_uart_pd u_uart_pd (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .auto_en_i(cfg_i.cr7[UART_AUTO_BIT[i]]),
         .direct_pd_i(cfg_i.cr2[UART_PD_BIT[i]]),
         .u_i(uart_i[i]),
         .tx_pd_o(uart_tx_pd_o[i]),
         .rx_pd_o(uart_rx_pd_o[i]),
         .ri_change_o(uart_ri_change_o[i])
      );
   end

   // ------------------------------------------------------------------
   // parallel port; registered every cycle so a mode change acts on the next clock
   // ------------------------------------------------------------------
   logic pp_direct;
   logic pp_auto;
   logic epp_idle;
   logic ecp_idle;

   assign pp_direct = cfg_i.cr1[apm_pkg::CR1_PP_PD_BIT];
   assign pp_auto = cfg_i.cr7[apm_pkg::CR7_PP_AUTO_BIT];
   assign epp_idle = !cfg_i.epp_en ||
                     (cfg_i.ecp_en && cfg_i.ecr_mode != apm_pkg::ECR_EPP);
   assign ecp_idle = !cfg_i.ecp_en ||
                     cfg_i.ecr_mode == apm_pkg::ECR_STD ||
                     cfg_i.ecr_mode == apm_pkg::ECR_BIDIR ||
                     cfg_i.ecr_mode == apm_pkg::ECR_EPP;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pp_pd_o <= 1'b0;
         epp_pd_o <= 1'b0;
         ecp_pd_o <= 1'b0;
      end else begin
         pp_pd_o <= pp_direct;
         epp_pd_o <= pp_direct || (pp_auto && epp_idle);
         ecp_pd_o <= pp_direct || (pp_auto && ecp_idle);
      end
   end

endmodule

// *** dv/apm_core_model.sv ***
// floppy core stand-in that reports an idle controller
`timescale 1ns/10ps
module apm_core_model (
   input wire logic step_i,             // step request from the bench
   output apm_pkg::apm_fdc_core_t fdc_o // core status to the manager
);
   // idle, no interrupt, heads unloaded, so only the timer gates sleep
   always_comb begin
      fdc_o = '0;
      fdc_o.status_a = 8'h5a;
      fdc_o.status_b = 8'ha5;
      fdc_o.input_status = 8'h3c;
      fdc_o.main_status = 8'h80;
      fdc_o.head_unloaded = 1'b1;
      fdc_o.step = step_i;
   end
endmodule

// *** dv/apm_power_mgr_monitor.sv ***
// port assertions for the power manager
`timescale 1ns/10ps
module apm_power_mgr_monitor #(
   parameter int unsigned IDLE_CYCLES = 20
) (
   input wire logic clk_i,                         // clock
   input wire logic nrst_i,                        // reset
   input wire logic [2:0] host_addr_i,             // offset
   input wire logic host_rd_i,                     // read
   input wire apm_pkg::apm_cfg_t cfg_i,            // config
   input wire apm_pkg::apm_fdc_core_t fdc_i,       // core
   input wire apm_pkg::apm_uart_in_t [1:0] uart_i, // serial
   input wire logic fdc_pd_o,                      // floppy down
   input wire logic fdc_data_rd_o,                 // data read
   input wire logic motor_on_oe_n_o,               // motor oe
   input wire logic drive_select_oe_n_o,           // select oe
   input wire logic write_gate_oe_n_o,             // gate oe
   input wire logic step_pulse_o,                  // step
   input wire logic [1:0] uart_tx_pd_o,            // tx down
   input wire logic [1:0] uart_ri_change_o,        // ring pulse
   input wire logic pp_pd_o,                       // parallel down
   input wire logic epp_pd_o,                      // epp down
   input wire logic ecp_pd_o                       // ecp down
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_ri_pulse;
      ##1 uart_ri_change_o[0] ##1 !uart_ri_change_o[0];
   endsequence
   a_status_stays_down: assert property (
      fdc_pd_o && cfg_i.cr7[7] && host_rd_i && host_addr_i inside {3'h0, 3'h1, 3'h7}
      |=> fdc_pd_o) else $error("status read woke floppy");
   a_data_read_wakes: assert property (
      host_rd_i && host_addr_i == 3'h5 |=> !fdc_pd_o && fdc_data_rd_o)
      else $error("data read did not wake floppy");
   a_drive_pins_float: assert property (
      {motor_on_oe_n_o, drive_select_oe_n_o, write_gate_oe_n_o} == {3{fdc_pd_o}})
      else $error("drive pin enable wrong");
   a_step_kept_driven: assert property (
      1 |=> step_pulse_o == $past(fdc_i.step)) else $error("step not driven");
   a_tx_write_wakes: assert property (
      uart_i[0].thr_write && !cfg_i.cr2[3] |=> !uart_tx_pd_o[0])
      else $error("transmit write did not wake");
   a_ring_still_seen: assert property (
      $changed(uart_i[0].ring_indicator) |-> s_ri_pulse) else $error("ring pulse missing");
   a_pp_direct_down: assert property (
      1 |=> pp_pd_o == $past(cfg_i.cr1[2])) else $error("parallel powerdown wrong");
   a_epp_sub_down: assert property (
      1 |=> epp_pd_o == $past(cfg_i.cr1[2] | (cfg_i.cr7[4] & (!cfg_i.epp_en
      | (cfg_i.ecp_en & cfg_i.ecr_mode != 3'h4))))) else $error("epp powerdown wrong");
   a_ecp_sub_down: assert property (
      1 |=> ecp_pd_o == $past(cfg_i.cr1[2] | (cfg_i.cr7[4] & (!cfg_i.ecp_en
      | cfg_i.ecr_mode inside {3'h0, 3'h1, 3'h4})))) else $error("ecp powerdown wrong");
endmodule
bind apm_power_mgr apm_power_mgr_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) i_mon (.*);

// *** dv/testbench.sv ***
// self-checking bench for the power manager
`timescale 1ns/10ps
module testbench;
   logic clk_i, nrst_i, rd, wr, step, fdc_pd, data_wr, motor_oe, sel_oe, step_o, pp, epp, ecp;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, fdc_data;
   logic [1:0] rate, txpd, rxpd, ric;
   apm_pkg::apm_cfg_t cfg;
   apm_pkg::apm_fdc_core_t fdc;
   apm_pkg::apm_drive_in_t drv;
   apm_pkg::apm_uart_in_t [1:0] uart;
   int bad_count = 0;
   int n_checks = 0;
   apm_core_model i_core (.step_i(step), .fdc_o(fdc));
   apm_power_mgr #(.IDLE_CYCLES(20)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .host_addr_i(addr), .host_rd_i(rd), .host_wr_i(wr), .host_wdata_i(wdata),
      .host_rdata_o(rdata), .cfg_i(cfg), .fdc_i(fdc), .fdc_data_rd_o(),
      .fdc_data_wr_o(data_wr), .fdc_data_o(fdc_data), .fdc_sw_reset_o(), .fdc_pd_o(fdc_pd),
      .drive_in_i(drv), .drive_in_o(), .motor_on_outputs_o(), .motor_on_oe_n_o(motor_oe),
      .drive_select_outputs_o(), .drive_select_oe_n_o(sel_oe), .write_stream_out_o(),
      .write_stream_oe_n_o(), .write_gate_o(), .write_gate_oe_n_o(), .step_pulse_o(step_o),
      .step_dir_o(), .head_side_select_o(), .density_select_o(), .rate_outputs_o(rate),
      .uart_i(uart), .uart_tx_pd_o(txpd), .uart_rx_pd_o(rxpd), .uart_ri_change_o(ric),
      .pp_pd_o(pp), .epp_pd_o(epp), .ecp_pd_o(ecp));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t byte %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t flag %b not %b", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic host(input logic r, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 {rd, wr, addr, wdata} = {r, !r, a, d};
      cyc(1);
      {rd, wr} = 2'b00;
   endtask
   // first half of the wait proves the timer has not run short
   task automatic nap();
      cyc(15);
      chk1(fdc_pd, 1'b0);
      for (int i = 0; i < 15 && fdc_pd !== 1'b1; i++) cyc(1);
      chk1(fdc_pd, 1'b1);
   endtask
   task automatic t_fdc();
      nap();
      chk1(motor_oe & sel_oe, 1'b1);
      step = 1'b1;
      cyc(2);
      chk1(step_o, 1'b1);
      host(1'b1, 3'h0, 8'h00);
      chk8(rdata, fdc.status_a);
      host(1'b1, 3'h1, 8'h00);
      chk8(rdata, fdc.status_b);
      host(1'b1, 3'h7, 8'h00);
      chk8(rdata, fdc.input_status);
      host(1'b0, 3'h7, 8'h02);
      host(1'b0, 3'h2, 8'h04);
      chk1(fdc_pd, 1'b1);
      host(1'b1, 3'h4, 8'h00);
      chk1(fdc_pd, 1'b0);
      chk8({6'h00, rate}, 8'h02);
      cyc(10);
      host(1'b1, 3'h5, 8'h00);
      nap();
      host(1'b0, 3'h5, 8'h3c);
      chk1(fdc_pd | !data_wr, 1'b0);
      chk8(fdc_data, 8'h3c);
      nap();
      host(1'b0, 3'h2, 8'h14);
      chk1(fdc_pd, 1'b0);
      host(1'b0, 3'h2, 8'h04);
   endtask
   task automatic t_uart();
      for (int p = 0; p < 2; p++) begin
         cfg.cr7[5+p] = 1'b1;
         uart[p] = 7'h7c;
         cyc(3);
         chk1(txpd[p], 1'b1);
         chk1(rxpd[p], 1'b1);
         uart[p].thr_write = 1'b1;
         cyc(1);
         uart[p].thr_write = 1'b0;
         chk1(txpd[p], 1'b0);
         uart[p].serial_receive_input = 1'b0;
         for (int i = 0; i < 4 && rxpd[p] !== 1'b0; i++) cyc(1);
         chk1(rxpd[p], 1'b0);
         uart[p].ring_indicator = 1'b1;
         for (int i = 0; i < 4 && ric[p] !== 1'b1; i++) cyc(1);
         chk1(ric[p], 1'b1);
         cfg.cr7[5+p] = 1'b0;
         cfg.cr2[3+4*p] = 1'b1;
         cyc(2);
         chk1(txpd[p], 1'b1);
         cfg.cr2[3+4*p] = 1'b0;
         cyc(2);
         chk1(txpd[p] | rxpd[p], 1'b0);
      end
   endtask
   task automatic t_pp();
      logic [2:0] m[4] = '{3'h0, 3'h1, 3'h4, 3'h3};
      {cfg.epp_en, cfg.ecp_en, cfg.cr7[4]} = 3'h7;
      foreach (m[i]) begin
         cfg.ecr_mode = m[i];
         cyc(2);
         chk1(epp, m[i] != 3'h4);
         chk1(ecp, m[i] != 3'h3);
      end
      {cfg.epp_en, cfg.ecp_en} = 2'b00;
      cyc(2);
      chk1(epp & ecp, 1'b1);
      cfg.cr7[4] = 1'b0;
      cyc(2);
      chk1(epp | ecp | pp, 1'b0);
      cfg.cr1[2] = 1'b1;
      cyc(2);
      chk1(pp & epp & ecp, 1'b1);
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {nrst_i, rd, wr, addr, wdata, step} = '0;
      {cfg, drv, uart} = '0;
      cfg.cr7 = 8'h80;
      repeat (3) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      t_fdc();
      t_uart();
      t_pp();
      conclude();
   end
   initial begin
      #50000;
      bad_count++;
      conclude();
   end
endmodule
